// *** hw/plaor_pkg.sv ***
package plaor_pkg;

  // Register byte addresses
  localparam logic [31:0] INTERRUPT_ROUTE_ADDR     = 32'hFFFF0B44;
  localparam logic [31:0] ADC_TRIGGER_ROUTE_ADDR   = 32'hFFFF0B48;
  localparam logic [31:0] SOFTWARE_INPUT_BITS_ADDR = 32'hFFFF0B4C;
  localparam logic [31:0] ELEMENT_OUTPUT_VIEW_ADDR = 32'hFFFF0B50;
  localparam logic [31:0] CONFIGURATION_LOCK_ADDR  = 32'hFFFF0B54;
  localparam logic [31:0] EVENT_STATUS_ADDR        = 32'hFFFF0B58;
  localparam logic [31:0] EVENT_MASK_ADDR          = 32'hFFFF0B5C;
  localparam logic [31:0] LOCK_STATE_ADDR          = 32'hFFFF0B60;

  // Reset values
  localparam logic [15:0] INTERRUPT_ROUTE_RST     = 16'h0000;
  localparam logic [4:0]  ADC_TRIGGER_ROUTE_RST   = 5'h00;
  localparam logic [15:0] SOFTWARE_INPUT_BITS_RST = 16'h0000;
  localparam logic [2:0]  EVENT_RST               = 3'h0;

  // Field positions
  localparam int FIRST_ARRAY_INTERRUPT_SRC_LSB = 0;
  localparam int FIRST_ARRAY_INTERRUPT_EN_BIT  = 4;
  localparam int SECOND_ARRAY_INTERRUPT_SRC_LSB = 8;
  localparam int SECOND_ARRAY_INTERRUPT_EN_BIT  = 12;
  localparam int ADC_SRC_LSB  = 0;
  localparam int ADC_EN_BIT   = 4;
  localparam int LOCK_BIT     = 0;
  localparam int SRC_W        = 4;

  // Writable bits of the interrupt route register
  localparam logic [15:0] INTERRUPT_ROUTE_MASK = 16'h1F1F;

  // Event status bits
  localparam int EV_FIRST_ARRAY_INTERRUPT = 0;
  localparam int EV_SECOND_ARRAY_INTERRUPT = 1;
  localparam int EV_ADC  = 2;
  localparam int EV_W    = 3;

endpackage

// *** hw/plaor_top.sv ***
// Register access over APB was decided locally.
`timescale 1ns/100ps
module plaor_top
(
  input  wire logic        sys_clk,         // System clock, 25 MHz
  input  wire logic        rst,             // Synchronous reset, active high
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB write
  input  wire logic [31:0] paddr,           // APB address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error, unmapped address
  input  wire logic [15:0] element_out,     // Element outputs, any element clock
  input  wire logic [15:0] elem_input_sel,  // Per element input-select control bit
  input  wire logic [15:0] elem_feedback,   // Per element feedback mux result
  output logic      [15:0] elem_data_in,    // Per element selected input
  output logic             first_array_interrupt,   // Routed first interrupt
  output logic             second_array_interrupt,  // Routed second interrupt
  output logic             adc_convst_request,      // Routed ADC start request
  output logic             config_locked,   // Freezes element configuration
  output logic             irq              // Block interrupt, level
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic pick_element(input logic [15:0] outs,
                                        input logic [3:0]  idx);
    pick_element = outs[idx];
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a == b);
  endfunction

  // ==========================================================================
  // Element output synchroniser
  // ==========================================================================
  // Element outputs may run on another clock
  logic [15:0] elem_sync1;
  logic [15:0] elem_sync2;
  logic [15:0] next_elem_sync1;
  logic [15:0] next_elem_sync2;

  always_comb
  begin
    next_elem_sync1 = element_out;
    next_elem_sync2 = elem_sync1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      elem_sync1 <= 16'h0000;
      elem_sync2 <= 16'h0000;
    end
    else
    begin
      elem_sync1 <= next_elem_sync1;
      elem_sync2 <= next_elem_sync2;
    end
  end

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic wr_strobe;
  logic setup;
  logic sel_irq_route;
  logic sel_adc_route;
  logic sel_sw_in;
  logic sel_out_view;
  logic sel_lock;
  logic sel_status;
  logic sel_mask;
  logic sel_lock_state;
  logic mapped;

  // Zero wait states; every access ends in its access cycle
  assign pready         = 1'b1;
  assign setup          = psel & ~penable;
  assign wr_strobe      = psel & penable & pwrite;
  assign sel_irq_route  = hit(paddr, plaor_pkg::INTERRUPT_ROUTE_ADDR);
  assign sel_adc_route  = hit(paddr, plaor_pkg::ADC_TRIGGER_ROUTE_ADDR);
  assign sel_sw_in      = hit(paddr, plaor_pkg::SOFTWARE_INPUT_BITS_ADDR);
  assign sel_out_view   = hit(paddr, plaor_pkg::ELEMENT_OUTPUT_VIEW_ADDR);
  assign sel_lock       = hit(paddr, plaor_pkg::CONFIGURATION_LOCK_ADDR);
  assign sel_status     = hit(paddr, plaor_pkg::EVENT_STATUS_ADDR);
  assign sel_mask       = hit(paddr, plaor_pkg::EVENT_MASK_ADDR);
  assign sel_lock_state = hit(paddr, plaor_pkg::LOCK_STATE_ADDR);
  assign mapped         = sel_irq_route | sel_adc_route | sel_sw_in | sel_out_view
                        | sel_lock | sel_status | sel_mask | sel_lock_state;

  // ==========================================================================
  // Configuration registers and lock
  // ==========================================================================
  logic [15:0] interrupt_route;
  logic [4:0]  adc_trigger_route;
  logic [15:0] software_input_bits;
  logic        lock_bit;
  logic        lock_used;
  logic [15:0] next_interrupt_route;
  logic [4:0]  next_adc_trigger_route;
  logic [15:0] next_software_input_bits;
  logic        next_lock_bit;
  logic        next_lock_used;

  always_comb
  begin
    next_interrupt_route     = interrupt_route;
    next_adc_trigger_route   = adc_trigger_route;
    next_software_input_bits = software_input_bits;
    next_lock_bit            = lock_bit;
    next_lock_used           = lock_used;
    if (wr_strobe && sel_irq_route && !lock_bit)
      next_interrupt_route = pwdata[15:0] & plaor_pkg::INTERRUPT_ROUTE_MASK;
    if (wr_strobe && sel_adc_route && !lock_bit)
      next_adc_trigger_route = pwdata[4:0];
    if (wr_strobe && sel_sw_in)
      next_software_input_bits = pwdata[15:0];
    // First lock write is consumed, whatever its data
    if (wr_strobe && sel_lock && !lock_used)
    begin
      next_lock_bit  = pwdata[plaor_pkg::LOCK_BIT];
      next_lock_used = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      interrupt_route     <= plaor_pkg::INTERRUPT_ROUTE_RST;
      adc_trigger_route   <= plaor_pkg::ADC_TRIGGER_ROUTE_RST;
      software_input_bits <= plaor_pkg::SOFTWARE_INPUT_BITS_RST;
      lock_bit            <= 1'b0;
      lock_used           <= 1'b0;
    end
    else
    begin
      interrupt_route     <= next_interrupt_route;
      adc_trigger_route   <= next_adc_trigger_route;
      software_input_bits <= next_software_input_bits;
      lock_bit            <= next_lock_bit;
      lock_used           <= next_lock_used;
    end
  end

  assign config_locked = lock_bit;

  // ==========================================================================
  // Output routing and element input select
  // ==========================================================================
  logic        next_first_irq;
  logic        next_second_irq;
  logic        next_adc_req;
  logic [15:0] next_elem_data_in;

  always_comb
  begin
    next_first_irq = interrupt_route[plaor_pkg::FIRST_ARRAY_INTERRUPT_EN_BIT]
                   & pick_element(elem_sync2,
                       interrupt_route[plaor_pkg::FIRST_ARRAY_INTERRUPT_SRC_LSB +: plaor_pkg::SRC_W]);
    next_second_irq = interrupt_route[plaor_pkg::SECOND_ARRAY_INTERRUPT_EN_BIT]
                    & pick_element(elem_sync2,
                        interrupt_route[plaor_pkg::SECOND_ARRAY_INTERRUPT_SRC_LSB +: plaor_pkg::SRC_W]);
    next_adc_req = adc_trigger_route[plaor_pkg::ADC_EN_BIT]
                 & pick_element(elem_sync2,
                     adc_trigger_route[plaor_pkg::ADC_SRC_LSB +: plaor_pkg::SRC_W]);
    for (int i = 0; i < 16; i++)
      next_elem_data_in[i] = elem_input_sel[i] ? elem_feedback[i]
                                               : software_input_bits[i];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      first_array_interrupt  <= 1'b0;
      second_array_interrupt <= 1'b0;
      adc_convst_request     <= 1'b0;
      elem_data_in           <= 16'h0000;
    end
    else
    begin
      first_array_interrupt  <= next_first_irq;
      second_array_interrupt <= next_second_irq;
      adc_convst_request     <= next_adc_req;
      elem_data_in           <= next_elem_data_in;
    end
  end

  // ==========================================================================
  // Event status and mask
  // ==========================================================================
  logic [2:0] prev_routed;
  logic [2:0] event_status;
  logic [2:0] event_mask;
  logic [2:0] rise;
  logic [2:0] next_prev_routed;
  logic [2:0] next_event_status;
  logic [2:0] next_event_mask;

  always_comb
  begin
    next_prev_routed = {adc_convst_request, second_array_interrupt,
                        first_array_interrupt};
    rise             = next_prev_routed & ~prev_routed;
    next_event_mask  = event_mask;
    next_event_status = event_status;
    if (wr_strobe && sel_mask)
      next_event_mask = pwdata[plaor_pkg::EV_W-1:0];
    if (wr_strobe && sel_status)
      next_event_status = next_event_status & ~pwdata[plaor_pkg::EV_W-1:0];
    // Set after clear so a same-cycle event is kept
    next_event_status = next_event_status | rise;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prev_routed  <= plaor_pkg::EVENT_RST;
      event_status <= plaor_pkg::EVENT_RST;
      event_mask   <= plaor_pkg::EVENT_RST;
    end
    else
    begin
      prev_routed  <= next_prev_routed;
      event_status <= next_event_status;
      event_mask   <= next_event_mask;
    end
  end

  // Level interrupt while any unmasked event is pending
  assign irq = |(event_status & event_mask);

  // ==========================================================================
  // Read data, captured in the setup cycle
  // ==========================================================================
  logic [31:0] next_prdata;
  logic        next_pslverr;

  always_comb
  begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup)
    begin
      next_pslverr = ~mapped;
      next_prdata  = 32'h00000000;
      if (!pwrite)
      begin
        if (sel_irq_route)
          next_prdata[15:0] = interrupt_route;
        if (sel_adc_route)
          next_prdata[4:0] = adc_trigger_route;
        if (sel_sw_in)
          next_prdata[15:0] = software_input_bits;
        if (sel_out_view)
          next_prdata[15:0] = elem_sync2;
        if (sel_status)
          next_prdata[plaor_pkg::EV_W-1:0] = event_status;
        if (sel_mask)
          next_prdata[plaor_pkg::EV_W-1:0] = event_mask;
        if (sel_lock_state)
          next_prdata[1:0] = {lock_used, lock_bit};
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule

// *** test/plaor_elem_model.sv ***
`timescale 1ns/100ps
// ==========
// Element array stand-in, outputs launched on sys_clk
module plaor_elem_model
(
  input  wire logic        sys_clk,        // System clock
  input  wire logic [15:0] pattern,        // Wanted element outputs
  output logic      [15:0] element_out,    // Element outputs
  output logic      [15:0] elem_feedback   // Feedback, inverse of outputs
);
  always_ff @(posedge sys_clk)
  begin
    element_out   <= pattern;
    elem_feedback <= ~pattern;
  end
endmodule

// *** test/plaor_assertions.sv ***
`timescale 1ns/100ps
module plaor_assertions
(
  input wire logic        sys_clk, rst,                  // Clock, reset
  input wire logic        psel, penable, pwrite, pready, // APB control
  input wire logic [31:0] paddr, pwdata, prdata,         // APB data
  input wire logic [15:0] element_out, elem_input_sel,   // Element side
  input wire logic [15:0] elem_feedback, elem_data_in,   // Element side
  input wire logic        first_array_interrupt,         // Routed outputs
  input wire logic        second_array_interrupt,        // Routed outputs
  input wire logic        adc_convst_request,            // Routed outputs
  input wire logic        config_locked                  // Lock
);
  // ==========
  // Shadow of routing state
  logic [15:0] ir, din, e1, e2;
  logic [4:0]  ad;
  wire         wr = psel & penable & pwrite;
  always_ff @(posedge sys_clk)
  begin
    e1 <= element_out;
    e2 <= e1;
    if (rst)
    begin
      ir  <= '0;
      ad  <= '0;
      din <= '0;
    end
    else
    begin
      if (wr && !config_locked && paddr == plaor_pkg::INTERRUPT_ROUTE_ADDR)
        ir <= pwdata[15:0] & plaor_pkg::INTERRUPT_ROUTE_MASK;
      if (wr && !config_locked && paddr == plaor_pkg::ADC_TRIGGER_ROUTE_ADDR)
        ad <= pwdata[4:0];
      if (wr && paddr == plaor_pkg::SOFTWARE_INPUT_BITS_ADDR)
        din <= pwdata[15:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========
  property p_first_array_interrupt;
    !$past(rst) |-> first_array_interrupt == $past(ir[4] & e2[ir[3:0]]);
  endproperty
  a_first_array_interrupt: assert property (p_first_array_interrupt) else $error("first interrupt wrong");
  property p_second_array_interrupt;
    !$past(rst) |-> second_array_interrupt == $past(ir[12] & e2[ir[11:8]]);
  endproperty
  a_second_array_interrupt: assert property (p_second_array_interrupt) else $error("second interrupt wrong");
  property p_adc;
    !$past(rst) |-> adc_convst_request == $past(ad[4] & e2[ad[3:0]]);
  endproperty
  a_adc: assert property (p_adc) else $error("adc request wrong");
  property p_din_sel;
    !$past(rst) |->
      elem_data_in == $past((elem_input_sel & elem_feedback) | (~elem_input_sel & din));
  endproperty
  a_din_sel: assert property (p_din_sel) else $error("element input wrong");
  property p_lock_hold;
    config_locked |=> config_locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
  property p_lock_cause;
    $rose(config_locked) |->
      $past(wr && paddr == plaor_pkg::CONFIGURATION_LOCK_ADDR && pwdata[0]);
  endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("lock without write");
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  property p_din_read;
    psel && penable && !pwrite && paddr == plaor_pkg::SOFTWARE_INPUT_BITS_ADDR
      |-> prdata == {16'h0000, $past(din)};
  endproperty
  a_din_read: assert property (p_din_read) else $error("input bits read wrong");
endmodule
bind plaor_top plaor_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .element_out(element_out), .elem_input_sel(elem_input_sel),
  .elem_feedback(elem_feedback), .elem_data_in(elem_data_in),
  .first_array_interrupt(first_array_interrupt), .second_array_interrupt(second_array_interrupt),
  .adc_convst_request(adc_convst_request), .config_locked(config_locked));

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] A_IR = plaor_pkg::INTERRUPT_ROUTE_ADDR;
  localparam logic [31:0] A_AD = plaor_pkg::ADC_TRIGGER_ROUTE_ADDR;
  localparam logic [31:0] A_DI = plaor_pkg::SOFTWARE_INPUT_BITS_ADDR;
  localparam logic [31:0] A_VW = plaor_pkg::ELEMENT_OUTPUT_VIEW_ADDR;
  localparam logic [31:0] A_LK = plaor_pkg::CONFIGURATION_LOCK_ADDR;
  localparam logic [31:0] A_ST = plaor_pkg::EVENT_STATUS_ADDR;
  localparam logic [31:0] A_MK = plaor_pkg::EVENT_MASK_ADDR;
  localparam logic [31:0] A_LS = plaor_pkg::LOCK_STATE_ADDR;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, fai, sai, adc, lck, irq;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [15:0] pat, sel, fb, eo, edi;
  int          mismatches, comparisons;
  plaor_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .element_out(eo), .elem_input_sel(sel), .elem_feedback(fb),
    .elem_data_in(edi), .first_array_interrupt(fai), .second_array_interrupt(sai),
    .adc_convst_request(adc), .config_locked(lck), .irq(irq));
  plaor_elem_model elem (.sys_clk(sys_clk), .pattern(pat), .element_out(eo),
    .elem_feedback(fb));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge so register effects have settled for the caller
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(q, e);
  endtask
  task automatic settle(input logic [15:0] p);
    pat <= p;
    repeat (6) @(posedge sys_clk);
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    rc(A_IR, 32'h00000000);
    chk({fai, sai, adc, lck, irq}, 32'h00000000);
    rc(A_AD, 32'h00000000);
    rc(A_DI, 32'h00000000);
    rc(A_VW, 32'h00000000);
    rc(A_LK, 32'h00000000);
    apb(1'b1, 32'hFFFF0B64, 32'hFFFFFFFF);
    chk(pslverr, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_route;
    for (int n = 0; n < 16; n++)
    begin
      apb(1'b1, A_IR, {19'h0, 1'b1, n[3:0], 3'h0, 1'b1, n[3:0]});
      apb(1'b1, A_AD, {27'h0, 1'b1, n[3:0]});
      settle(16'h0001 << n);
      chk({fai, sai, adc}, 3'h7);
      settle(~(16'h0001 << n));
      chk({fai, sai, adc}, 3'h0);
    end
    apb(1'b1, A_IR, 32'h00000F0F);
    apb(1'b1, A_AD, 32'h0000000F);
    settle(16'hFFFF);
    chk({fai, sai, adc}, 3'h0);
    apb(1'b1, A_IR, 32'hFFFFFFFF);
    rc(A_IR, 32'h00001F1F);
    apb(1'b1, A_AD, 32'hFFFFFFFF);
    rc(A_AD, 32'h0000001F);
    $display("test route done");
  endtask
  task automatic t_din;
    apb(1'b1, A_DI, 32'hFFFFA5C3);
    rc(A_DI, 32'h0000A5C3);
    sel <= 16'h00FF;
    settle(16'h1234);
    chk(edi, 16'h00CB | 16'hA500);
    sel <= 16'h0000;
    $display("test input bits done");
  endtask
  task automatic t_view;
    settle(16'h5AC3);
    rc(A_VW, 32'h00005AC3);
    settle(16'h0F0F);
    apb(1'b1, A_VW, 32'hFFFFFFFF);
    rc(A_VW, 32'h00000F0F);
    $display("test view done");
  endtask
  task automatic t_irq;
    apb(1'b1, A_MK, 32'h00000001);
    apb(1'b1, A_IR, 32'h00000010);
    settle(16'h0000);
    apb(1'b1, A_ST, 32'h00000007);
    chk(irq, 1'b0);
    settle(16'h0001);
    chk(irq, 1'b1);
    rc(A_ST, 32'h00000001);
    rc(A_MK, 32'h00000001);
    apb(1'b1, A_MK, 32'h00000000);
    chk(irq, 1'b0);
    apb(1'b1, A_MK, 32'h00000001);
    chk(irq, 1'b1);
    apb(1'b1, A_ST, 32'h00000001);
    chk(irq, 1'b0);
    $display("test interrupt done");
  endtask
  task automatic t_lock;
    apb(1'b1, A_LK, 32'h00000001);
    chk(lck, 1'b1);
    rc(A_LS, 32'h00000003);
    apb(1'b1, A_IR, 32'h00000000);
    rc(A_IR, 32'h00000010);
    apb(1'b1, A_AD, 32'h00000000);
    rc(A_AD, 32'h0000001F);
    apb(1'b1, A_DI, 32'h00001234);
    rc(A_DI, 32'h00001234);
    apb(1'b1, A_LK, 32'h00000000);
    chk(lck, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    chk(lck, 1'b0);
    apb(1'b1, A_LK, 32'h00000000);
    apb(1'b1, A_LK, 32'h00000001);
    chk(lck, 1'b0);
    rc(A_LS, 32'h00000002);
    $display("test lock done");
  endtask
  // ==========
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    {paddr, pwdata} = '0;
    {pat, sel} = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_din();
    t_view();
    t_irq();
    t_lock();
    finish_test();
  end
endmodule
